// [shared/ifc_pkg.sv]
package ifc_pkg;
	// ---------------------------------------------
	// bus and register map
	// ---------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_FLAG0 = 4'h4;
	localparam logic [3:0] OFS_FLAG1 = 4'h8;
	localparam logic [3:0] OFS_FLAG4 = 4'hC;
	localparam logic [3:0] OFS_ENA0 = 4'h1;
	localparam logic [3:0] OFS_ENA1 = 4'h2;
	localparam logic [3:0] OFS_ENA4 = 4'h3;
	localparam logic [31:0] UNMAPPED_VALUE = 32'h00000000;
	// ---------------------------------------------
	// control register fields
	// ---------------------------------------------
	localparam int CTRL_ALT_BIT = 15;
	localparam int CTRL_TIMED_IRQ_DISABLE_ACTIVE_BIT = 14;
	localparam int CTRL_EP0_BIT = 0;
	localparam logic [15:0] CTRL_WMASK = 16'h8007;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// ---------------------------------------------
	// implemented flag positions
	// ---------------------------------------------
	localparam logic [15:0] FLAG0_MASK = 16'hBF8F;
	localparam logic [15:0] FLAG1_MASK = 16'h201F;
	localparam logic [15:0] FLAG4_MASK = 16'h2102;
	localparam logic [15:0] FLAG_RESET = 16'h0000;
	localparam int EXT0_POS = 0;
	localparam int EXT1_POS = 4;
	localparam int EXT2_POS = 13;
	localparam int POS_NONVOL = 15;
	localparam int POS_CONV = 13;
	localparam int POS_SER_TX = 12;
	localparam int POS_SER_RX = 11;
	localparam int POS_SPI_EV = 10;
	localparam int POS_SPI_FLT = 9;
	localparam int POS_TMR3 = 8;
	localparam int POS_TMR2 = 7;
	localparam int POS_TMR1 = 3;
	localparam int POS_CMP_OUT = 2;
	localparam int POS_CAP_IN = 1;
	localparam int POS_PIN_CHG = 3;
	localparam int POS_COMPARATOR = 2;
	localparam int POS_I2C_MST = 1;
	localparam int POS_I2C_SLV = 0;
	localparam int POS_CHARGE = 13;
	localparam int POS_VDET = 8;
	localparam int POS_SER_ERR = 1;
	localparam int NUM_EXT = 3;
	localparam int NUM_FREG = 3;
endpackage : ifc_pkg

// [shared/ifc_edge_if.sv]
`timescale 1ns/10ps
interface ifc_edge_if;
	logic [2:0] pin;
	logic [2:0] polarity;
	logic [2:0] event_pulse;
	modport detector (input pin, input polarity, output event_pulse);
	modport user (output pin, output polarity, input event_pulse);
endinterface : ifc_edge_if

// [logic/ifc_edge_detect.sv]
`timescale 1ns/10ps
module ifc_edge_detect
	import ifc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pins and polarity
	ifc_edge_if.detector edge_bus
);
	logic [NUM_EXT-1:0] pin_prev_ff;
	logic [NUM_EXT-1:0] nxt_pin_prev;

	assign nxt_pin_prev = edge_bus.pin;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// start from the pin level: no false edge out of reset
			pin_prev_ff <= nxt_pin_prev;
		end else begin
			pin_prev_ff <= nxt_pin_prev;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_edge
			// falling when polarity set, rising otherwise
			assign edge_bus.event_pulse[gi] = edge_bus.polarity[gi] ?
				(pin_prev_ff[gi] & ~edge_bus.pin[gi]) :
				(~pin_prev_ff[gi] & edge_bus.pin[gi]);
		end
	endgenerate
endmodule : ifc_edge_detect

// [logic/ifc_flag_ctrl.sv]
`timescale 1ns/10ps
module ifc_flag_ctrl
	import ifc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [ifc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [ifc_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [ifc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// peripheral request pulses, register 0 layout
	input wire logic nonvolatile_write_req,
	input wire logic converter_done_req,
	input wire logic serial_tx_req,
	input wire logic serial_rx_req,
	input wire logic spi_event_req,
	input wire logic spi_fault_req,
	input wire logic timer_three_req,
	input wire logic timer_two_req,
	input wire logic timer_one_req,
	input wire logic compare_out_req,
	input wire logic capture_in_req,
	// register 1 layout
	input wire logic pin_change_req,
	input wire logic comparator_req,
	input wire logic i2c_master_event_req,
	input wire logic i2c_slave_event_req,
	// register 4 layout
	input wire logic charge_time_req,
	input wire logic voltage_detect_req,
	input wire logic serial_error_req,
	// external pins
	input wire logic [2:0] ext_pin,
	// timed disable status from the cpu
	input wire logic timed_disable_in,
	// toward the cpu
	output logic alt_vector_select,
	output logic [ifc_pkg::REG_W-1:0] irq_pending0,
	output logic [ifc_pkg::REG_W-1:0] irq_pending1,
	output logic [ifc_pkg::REG_W-1:0] irq_pending4,
	output logic irq_any
);
	import ifc_pkg::*;

	// ---------------------------------------------
	// state
	// ---------------------------------------------
	logic [REG_W-1:0] ctrl_ff;
	logic [REG_W-1:0] nxt_ctrl;
	logic timed_irq_disable_active_ff;
	logic [REG_W-1:0] flag_ff [NUM_FREG];
	logic [REG_W-1:0] nxt_flag [NUM_FREG];
	logic [REG_W-1:0] ena_ff [NUM_FREG];
	logic [REG_W-1:0] nxt_ena [NUM_FREG];
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic ack_ff;

	// ---------------------------------------------
	// edge detectors
	// ---------------------------------------------
	ifc_edge_if edge_bus ();
	assign edge_bus.pin = ext_pin;
	// named polarity fields
	wire ext_pin0_edge_polarity = ctrl_ff[CTRL_EP0_BIT];
	wire ext_pin1_edge_polarity = ctrl_ff[CTRL_EP0_BIT + 1];
	wire ext_pin2_edge_polarity = ctrl_ff[CTRL_EP0_BIT + 2];
	assign edge_bus.polarity = {ext_pin2_edge_polarity, ext_pin1_edge_polarity,
		ext_pin0_edge_polarity};

	ifc_edge_detect u_edge (
		.clk_sys(clk_sys),
		.rst(rst),
		.edge_bus(edge_bus)
	);

	// ---------------------------------------------
	// hardware set vectors
	// ---------------------------------------------
	logic [REG_W-1:0] hw_set [NUM_FREG];
	assign hw_set[0] = {nonvolatile_write_req, 1'b0, converter_done_req, serial_tx_req,
		serial_rx_req, spi_event_req, spi_fault_req, timer_three_req,
		timer_two_req, 3'b000, timer_one_req, compare_out_req, capture_in_req,
		edge_bus.event_pulse[0]};
	assign hw_set[1] = {2'b00, edge_bus.event_pulse[2], 8'h00, edge_bus.event_pulse[1],
		pin_change_req, comparator_req, i2c_master_event_req,
		i2c_slave_event_req};
	assign hw_set[2] = {2'b00, charge_time_req, 4'h0, voltage_detect_req, 6'h00,
		serial_error_req, 1'b0};

	logic [REG_W-1:0] flag_mask [NUM_FREG];
	assign flag_mask[0] = FLAG0_MASK;
	assign flag_mask[1] = FLAG1_MASK;
	assign flag_mask[2] = FLAG4_MASK;

	// ---------------------------------------------
	// bus decode
	// ---------------------------------------------
	wire req = (avs_read | avs_write) & ~ack_ff;
	wire wr_take = avs_write & ack_ff;
	wire lo_en = avs_byteenable[0];
	wire hi_en = avs_byteenable[1];
	wire [REG_W-1:0] byte_mask = {{8{hi_en}}, {8{lo_en}}};
	wire [REG_W-1:0] wdata16 = avs_writedata[REG_W-1:0];
	wire sel_ctrl = (avs_address == OFS_CTRL);
	wire [NUM_FREG-1:0] sel_flag = {avs_address == OFS_FLAG4,
		avs_address == OFS_FLAG1, avs_address == OFS_FLAG0};
	wire [NUM_FREG-1:0] sel_ena = {avs_address == OFS_ENA4,
		avs_address == OFS_ENA1, avs_address == OFS_ENA0};

	// one wait cycle, answer on the second edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end

	// ---------------------------------------------
	// control register
	// ---------------------------------------------
	wire ctrl_we = wr_take & sel_ctrl;
	wire [REG_W-1:0] ctrl_wm = CTRL_WMASK & byte_mask;
	assign nxt_ctrl = ctrl_we ? ((ctrl_ff & ~ctrl_wm) | (wdata16 & ctrl_wm)) : ctrl_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_ff <= CTRL_RESET;
			timed_irq_disable_active_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			timed_irq_disable_active_ff <= timed_disable_in;
		end
	end

	assign alt_vector_select = ctrl_ff[CTRL_ALT_BIT];

	wire [REG_W-1:0] ctrl_view;
	assign ctrl_view = (ctrl_ff & CTRL_WMASK) |
		(REG_W'(timed_irq_disable_active_ff) << CTRL_TIMED_IRQ_DISABLE_ACTIVE_BIT);

	// ---------------------------------------------
	// flags and enables
	// ---------------------------------------------
	genvar gr;
	generate
		for (gr = 0; gr < NUM_FREG; gr++) begin : g_reg
			wire fwe = wr_take & sel_flag[gr];
			wire ewe = wr_take & sel_ena[gr];
			wire [REG_W-1:0] wm = flag_mask[gr] & byte_mask;
			wire [REG_W-1:0] sw_val = fwe ? ((flag_ff[gr] & ~wm) | (wdata16 & wm)) :
				flag_ff[gr];
			// set wins over clear, flag held until written 0
			assign nxt_flag[gr] = (sw_val | hw_set[gr]) & flag_mask[gr];
			assign nxt_ena[gr] = ewe ? ((ena_ff[gr] & ~wm) | (wdata16 & wm)) : ena_ff[gr];

			always_ff @(posedge clk_sys) begin
				if (rst) begin
					flag_ff[gr] <= FLAG_RESET;
					ena_ff[gr] <= FLAG_RESET;
				end else begin
					flag_ff[gr] <= nxt_flag[gr];
					ena_ff[gr] <= nxt_ena[gr];
				end
			end
		end
	endgenerate

	// ---------------------------------------------
	// register 0 fields
	// ---------------------------------------------
	// flags
	wire nonvolatile_write_flag = flag_ff[0][POS_NONVOL];
	wire converter_done_flag = flag_ff[0][POS_CONV];
	wire serial_tx_flag = flag_ff[0][POS_SER_TX];
	wire serial_rx_flag = flag_ff[0][POS_SER_RX];
	wire spi_event_flag = flag_ff[0][POS_SPI_EV];
	wire spi_fault_flag = flag_ff[0][POS_SPI_FLT];
	wire timer_three_flag = flag_ff[0][POS_TMR3];
	wire timer_two_flag = flag_ff[0][POS_TMR2];
	wire timer_one_flag = flag_ff[0][POS_TMR1];
	wire compare_out_flag = flag_ff[0][POS_CMP_OUT];
	wire capture_in_flag = flag_ff[0][POS_CAP_IN];
	wire ext_pin0_flag = flag_ff[0][EXT0_POS];

	// enables at the same positions
	wire nonvolatile_write_ena = ena_ff[0][POS_NONVOL];
	wire converter_done_ena = ena_ff[0][POS_CONV];
	wire serial_tx_ena = ena_ff[0][POS_SER_TX];
	wire serial_rx_ena = ena_ff[0][POS_SER_RX];
	wire spi_event_ena = ena_ff[0][POS_SPI_EV];
	wire spi_fault_ena = ena_ff[0][POS_SPI_FLT];
	wire timer_three_ena = ena_ff[0][POS_TMR3];
	wire timer_two_ena = ena_ff[0][POS_TMR2];
	wire timer_one_ena = ena_ff[0][POS_TMR1];
	wire compare_out_ena = ena_ff[0][POS_CMP_OUT];
	wire capture_in_ena = ena_ff[0][POS_CAP_IN];
	wire ext_pin0_ena = ena_ff[0][EXT0_POS];

	// pending: flag gated by its enable
	wire nonvolatile_write_pend = nonvolatile_write_flag & nonvolatile_write_ena;
	wire converter_done_pend = converter_done_flag & converter_done_ena;
	wire serial_tx_pend = serial_tx_flag & serial_tx_ena;
	wire serial_rx_pend = serial_rx_flag & serial_rx_ena;
	wire spi_event_pend = spi_event_flag & spi_event_ena;
	wire spi_fault_pend = spi_fault_flag & spi_fault_ena;
	wire timer_three_pend = timer_three_flag & timer_three_ena;
	wire timer_two_pend = timer_two_flag & timer_two_ena;
	wire timer_one_pend = timer_one_flag & timer_one_ena;
	wire compare_out_pend = compare_out_flag & compare_out_ena;
	wire capture_in_pend = capture_in_flag & capture_in_ena;
	wire ext_pin0_pend = ext_pin0_flag & ext_pin0_ena;

	// read views
	wire [REG_W-1:0] flag0_view = {nonvolatile_write_flag, 1'b0, converter_done_flag,
		serial_tx_flag, serial_rx_flag, spi_event_flag, spi_fault_flag, timer_three_flag,
		timer_two_flag, 3'b000, timer_one_flag, compare_out_flag, capture_in_flag,
		ext_pin0_flag};
	wire [REG_W-1:0] ena0_view = {nonvolatile_write_ena, 1'b0, converter_done_ena,
		serial_tx_ena, serial_rx_ena, spi_event_ena, spi_fault_ena, timer_three_ena,
		timer_two_ena, 3'b000, timer_one_ena, compare_out_ena, capture_in_ena,
		ext_pin0_ena};

	assign irq_pending0 = {nonvolatile_write_pend, 1'b0, converter_done_pend,
		serial_tx_pend, serial_rx_pend, spi_event_pend, spi_fault_pend, timer_three_pend,
		timer_two_pend, 3'b000, timer_one_pend, compare_out_pend, capture_in_pend,
		ext_pin0_pend};

	// ---------------------------------------------
	// register 1 fields
	// ---------------------------------------------
	// flags
	wire ext_pin2_flag = flag_ff[1][EXT2_POS];
	wire ext_pin1_flag = flag_ff[1][EXT1_POS];
	wire pin_change_flag = flag_ff[1][POS_PIN_CHG];
	wire comparator_flag = flag_ff[1][POS_COMPARATOR];
	wire i2c_master_event_flag = flag_ff[1][POS_I2C_MST];
	wire i2c_slave_event_flag = flag_ff[1][POS_I2C_SLV];

	// enables at the same positions
	wire ext_pin2_ena = ena_ff[1][EXT2_POS];
	wire ext_pin1_ena = ena_ff[1][EXT1_POS];
	wire pin_change_ena = ena_ff[1][POS_PIN_CHG];
	wire comparator_ena = ena_ff[1][POS_COMPARATOR];
	wire i2c_master_event_ena = ena_ff[1][POS_I2C_MST];
	wire i2c_slave_event_ena = ena_ff[1][POS_I2C_SLV];

	// pending: flag gated by its enable
	wire ext_pin2_pend = ext_pin2_flag & ext_pin2_ena;
	wire ext_pin1_pend = ext_pin1_flag & ext_pin1_ena;
	wire pin_change_pend = pin_change_flag & pin_change_ena;
	wire comparator_pend = comparator_flag & comparator_ena;
	wire i2c_master_event_pend = i2c_master_event_flag & i2c_master_event_ena;
	wire i2c_slave_event_pend = i2c_slave_event_flag & i2c_slave_event_ena;

	// read views
	wire [REG_W-1:0] flag1_view = {2'b00, ext_pin2_flag, 8'h00, ext_pin1_flag,
		pin_change_flag, comparator_flag, i2c_master_event_flag,
		i2c_slave_event_flag};
	wire [REG_W-1:0] ena1_view = {2'b00, ext_pin2_ena, 8'h00, ext_pin1_ena,
		pin_change_ena, comparator_ena, i2c_master_event_ena,
		i2c_slave_event_ena};

	assign irq_pending1 = {2'b00, ext_pin2_pend, 8'h00, ext_pin1_pend,
		pin_change_pend, comparator_pend, i2c_master_event_pend,
		i2c_slave_event_pend};

	// ---------------------------------------------
	// register 4 fields
	// ---------------------------------------------
	// flags
	wire charge_time_flag = flag_ff[2][POS_CHARGE];
	wire voltage_detect_flag = flag_ff[2][POS_VDET];
	wire serial_error_flag = flag_ff[2][POS_SER_ERR];

	// enables at the same positions
	wire charge_time_ena = ena_ff[2][POS_CHARGE];
	wire voltage_detect_ena = ena_ff[2][POS_VDET];
	wire serial_error_ena = ena_ff[2][POS_SER_ERR];

	// pending: flag gated by its enable
	wire charge_time_pend = charge_time_flag & charge_time_ena;
	wire voltage_detect_pend = voltage_detect_flag & voltage_detect_ena;
	wire serial_error_pend = serial_error_flag & serial_error_ena;

	// read views
	wire [REG_W-1:0] flag4_view = {2'b00, charge_time_flag, 4'h0, voltage_detect_flag,
		6'h00, serial_error_flag, 1'b0};
	wire [REG_W-1:0] ena4_view = {2'b00, charge_time_ena, 4'h0, voltage_detect_ena,
		6'h00, serial_error_ena, 1'b0};

	assign irq_pending4 = {2'b00, charge_time_pend, 4'h0, voltage_detect_pend,
		6'h00, serial_error_pend, 1'b0};

	// ---------------------------------------------
	// requests to the cpu
	// ---------------------------------------------
	// any enabled request
	assign irq_any = |{irq_pending0, irq_pending1, irq_pending4};

	// ---------------------------------------------
	// read path
	// ---------------------------------------------
	wire [REG_W-1:0] rd_sel;
	assign rd_sel = sel_ctrl ? ctrl_view :
		sel_flag[0] ? flag0_view :
		sel_flag[1] ? flag1_view :
		sel_flag[2] ? flag4_view :
		sel_ena[0] ? ena0_view :
		sel_ena[1] ? ena1_view :
		sel_ena[2] ? ena4_view : UNMAPPED_VALUE[REG_W-1:0];
	assign nxt_rdata = (req & avs_read) ? {16'h0000, rd_sel} : rdata_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign avs_readdata = rdata_ff;
endmodule : ifc_flag_ctrl

// [tb/ifc_src_model.sv]
`timescale 1ns/10ps
// peripheral request sources: one-cycle pulses on command
module ifc_src_model (
	// clock
	input wire logic clk_sys,
	// command
	input wire logic go,
	input wire logic [17:0] mask,
	// request pulses
	output logic [17:0] req
);
	always_ff @(posedge clk_sys) begin
		req <= go ? mask : 18'h00000;
	end
endmodule : ifc_src_model

// [tb/ifc_flag_ctrl_chk.sv]
`timescale 1ns/10ps
module ifc_flag_ctrl_chk
	import ifc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [ifc_pkg::DATA_W-1:0] avs_readdata,
	// cpu side
	input wire logic alt_vector_select,
	input wire logic [ifc_pkg::REG_W-1:0] irq_pending0,
	input wire logic [ifc_pkg::REG_W-1:0] irq_pending1,
	input wire logic [ifc_pkg::REG_W-1:0] irq_pending4,
	input wire logic irq_any
);
	import ifc_pkg::*;
	wire logic wr_done = avs_write && !avs_waitrequest;
	wire logic [47:0] pend = {irq_pending0, irq_pending1, irq_pending4};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_one_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer missing after one wait cycle");
	a_reset_zero: assert property ($past(rst) |-> !irq_any && !alt_vector_select)
		else $error("outputs not zero after reset");
	a_flags_hold: assert property (
		!wr_done |=> (pend & $past(pend)) == $past(pend))
		else $error("pending flag fell without a write");
	a_pend_mask: assert property (
		(pend & ~{FLAG0_MASK, FLAG1_MASK, FLAG4_MASK}) == 48'h000000000000)
		else $error("unimplemented pending bit set");
	a_any_or: assert property (irq_any == |pend)
		else $error("irq_any differs from pending");
	a_rd_upper: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("upper read lanes not zero");
	a_alt_write: assert property ($changed(alt_vector_select) |-> $past(wr_done))
		else $error("vector select moved without a write");
	a_rdata_keep: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");
endmodule : ifc_flag_ctrl_chk
bind ifc_flag_ctrl ifc_flag_ctrl_chk u_ifc_flag_ctrl_chk (.clk_sys(clk_sys), .rst(rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.avs_readdata(avs_readdata), .alt_vector_select(alt_vector_select),
	.irq_pending0(irq_pending0), .irq_pending1(irq_pending1), .irq_pending4(irq_pending4),
	.irq_any(irq_any));

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
	import ifc_pkg::*;
	logic clk_sys, rst, rd_en, wr_en, wreq, go, tdis, alt, any_irq;
	logic [3:0] adr, lanes, be;
	logic [31:0] wdat, rdat, seed, expq[$];
	logic [17:0] mask, req, m;
	logic [2:0] pins;
	logic [15:0] p0, p1, p4, e0, e1, e4;
	int failures, tests_run;
	ifc_src_model u_ifc_src_model (.clk_sys(clk_sys), .go(go), .mask(mask), .req(req));
	ifc_flag_ctrl u_ifc_flag_ctrl (
		.clk_sys(clk_sys), .rst(rst), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
		.avs_writedata(wdat), .avs_byteenable(lanes), .avs_readdata(rdat), .avs_waitrequest(wreq),
		.nonvolatile_write_req(req[10]), .converter_done_req(req[9]), .serial_tx_req(req[8]),
		.serial_rx_req(req[7]), .spi_event_req(req[6]), .spi_fault_req(req[5]),
		.timer_three_req(req[4]), .timer_two_req(req[3]), .timer_one_req(req[2]),
		.compare_out_req(req[1]), .capture_in_req(req[0]), .pin_change_req(req[14]),
		.comparator_req(req[13]), .i2c_master_event_req(req[12]), .i2c_slave_event_req(req[11]),
		.charge_time_req(req[17]), .voltage_detect_req(req[16]), .serial_error_req(req[15]),
		.ext_pin(pins), .timed_disable_in(tdis), .alt_vector_select(alt), .irq_pending0(p0),
		.irq_pending1(p1), .irq_pending4(p4), .irq_any(any_irq));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic give_verdict();
		if (failures == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		adr <= a;
		wr_en <= w;
		rd_en <= !w;
		wdat <= d;
		lanes <= be;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		if (n >= 50) begin
			chk("waitrequest", 32'h0, {31'h0, wreq});
			give_verdict();
		end
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h00000000);
	endtask : rd
	task automatic pulse(input logic [17:0] v);
		@(posedge clk_sys);
		go <= 1'b1;
		mask <= v;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : pulse
	// read data monitor
	always @(posedge clk_sys) begin
		if (rd_en === 1'b1 && wreq === 1'b0 && expq.size() > 0) chk("readdata", expq.pop_front(), rdat);
	end
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		{rst, rd_en, wr_en, go, tdis, adr, wdat, mask, pins, be} = {1'b1, 61'h0, 4'h3};
		{failures, tests_run, e0, e1, e4, seed} = {64'h0, 48'h0, 32'h7251};
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 16; i++) rd(i[3:0], 32'h00000000);
		tdis <= 1'b1;
		wr(OFS_CTRL, 32'h0000FFFF);
		rd(OFS_CTRL, 32'h0000C007);
		chk("alt_vector_select", 32'h1, {31'h0, alt});
		tdis <= 1'b0;
		be = 4'h1;
		wr(OFS_CTRL, 32'h00000005);
		be = 4'h3;
		rd(OFS_CTRL, 32'h00008005);
		pins <= 3'b111;
		rd(OFS_FLAG1, 32'h00000010);
		rd(OFS_FLAG0, 32'h00000000);
		pins <= 3'b000;
		rd(OFS_FLAG0, 32'h00000001);
		rd(OFS_FLAG1, 32'h00002010);
		wr(OFS_FLAG0, 32'h0);
		wr(OFS_FLAG1, 32'h0);
		for (int r = 0; r < 4; r++) begin
			seed = xs(seed);
			m = seed[17:0];
			pulse(m);
			e0 |= {m[10], 1'b0, m[9:3], 3'h0, m[2:0], 1'b0};
			e1 |= {12'h000, m[14:11]};
			e4 |= {2'h0, m[17], 4'h0, m[16], 6'h00, m[15], 1'b0};
			rd(OFS_FLAG0, {16'h0000, e0});
			rd(OFS_FLAG1, {16'h0000, e1});
			rd(OFS_FLAG4, {16'h0000, e4});
		end
		wr(OFS_FLAG4, 32'h0);
		rd(OFS_FLAG4, 32'h0);
		wr(OFS_ENA0, 32'hFFFF);
		wr(OFS_ENA4, 32'hFFFF);
		rd(OFS_ENA0, 32'h0000BF8F);
		pulse(18'h3FFFF);
		chk("irq_pending0", 32'hBF8E, {16'h0, p0});
		chk("irq_pending1", 32'h0, {16'h0, p1});
		chk("irq_pending4", 32'h2102, {16'h0, p4});
		chk("irq_any", 32'h1, {31'h0, any_irq});
		wr(OFS_FLAG0, 32'hFFFF);
		rd(OFS_FLAG0, 32'h0000BF8F);
		wr(OFS_ENA0, 32'h0);
		@(posedge clk_sys);
		chk("irq_pending0", 32'h0, {16'h0, p0});
		wr(OFS_FLAG0, 32'h0);
		fork
			wr(OFS_FLAG0, 32'h0);
			pulse(18'h00004);
		join
		rd(OFS_FLAG0, 32'h00000008);
		@(posedge clk_sys);
		chk("read_queue", 32'h0, expq.size());
		give_verdict();
	end
endmodule : testbench
